/* File: logic/rbs_pkg.sv */
`default_nettype none
package rbs_pkg;
	// apb map
	localparam logic [11:0] RBS_ADDR_CONTROL = 12'h000;
	localparam logic [11:0] RBS_ADDR_STATUS  = 12'h004;
	// control register fields
	localparam int RBS_SWEN_BIT  = 7;
	localparam int RBS_READY_BIT = 0;
	localparam logic RBS_SWEN_RST = 1'b1;
	// status register fields
	localparam int RBS_ST_CORE_RST_BIT = 0;
	localparam int RBS_ST_DET_EN_BIT   = 1;
	localparam int RBS_ST_TIMER_BIT    = 2;
	localparam int RBS_ST_BOR_BIT      = 3;
	// brown-out modes
	localparam logic [1:0] RBS_MODE_OFF   = 2'h0;
	localparam logic [1:0] RBS_MODE_SW    = 2'h1;
	localparam logic [1:0] RBS_MODE_NOSLP = 2'h2;
	localparam logic [1:0] RBS_MODE_ON    = 2'h3;
	// timing
	localparam longint RBS_CLK_HZ        = 100000000;
	localparam longint RBS_POWERUP_DELAY_TIMER_MS       = 64;
	localparam longint RBS_POWERUP_DELAY_TIMER_CYCLES   = RBS_POWERUP_DELAY_TIMER_MS * RBS_CLK_HZ / 1000;
	localparam int     RBS_FILTER_NS     = 1000;
	localparam int     RBS_FILTER_CYCLES = (RBS_FILTER_NS + 9) / 10;

	typedef enum logic [1:0] {
		RBS_ST_HOLD  = 2'b00,
		RBS_ST_DELAY = 2'b01,
		RBS_ST_READY = 2'b11,
		RBS_ST_RUN   = 2'b10
	} rbs_state_t;

	typedef struct packed {
		logic       power_low;
		logic       supply_below_bor;
		logic       det_ready;
		logic       sleep;
	} rbs_analog_t;

	typedef struct packed {
		logic [1:0] brownout_mode_sel;
		logic       brownout_level_sel;
		logic       powerup_delay_disable_n;
	} rbs_config_t;
endpackage
`default_nettype wire

/* File: logic/rbs_sequencer.sv */
// Local design decisions: the register offsets and the APB slave port.
`default_nettype none
module rbs_sequencer #(
	parameter longint POWERUP_DELAY_TIMER_CYCLES   = rbs_pkg::RBS_POWERUP_DELAY_TIMER_CYCLES,
	parameter int     FILTER_CYCLES = rbs_pkg::RBS_FILTER_CYCLES
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire rbs_pkg::rbs_analog_t analog_in,
	input  wire rbs_pkg::rbs_config_t config_in,
	output logic                      detector_enable,
	output logic                      brownout_level_sel,
	output logic                      brownout_reset,
	output logic                      core_reset,
	output logic                      wake_ready
);
	import rbs_pkg::*;

	////////////////////////////////////////////////////////////////////
	// detector mode group
	logic        det_en_r;
	logic        det_en_nxt;
	logic        level_r;
	logic        level_nxt;
	logic        circuit_ready;
	logic        wait_ready;
	logic        sleep_wait;

	// brown-out filter group
	logic        bor_r;
	logic        bor_nxt;
	logic [31:0] filt_cnt_r;
	logic [31:0] filt_cnt_nxt;
	logic        filt_done;

	// reset sequence group
	logic [63:0] powerup_delay_timer_cnt_r;
	logic [63:0] powerup_delay_timer_cnt_nxt;
	rbs_state_t  state_r;
	rbs_state_t  state_nxt;
	logic        core_rst_r;
	logic        core_rst_nxt;
	logic        wake_r;
	logic        wake_nxt;
	logic        powerup_delay_timer_done;
	logic        start_ok;
	logic        wake_ok;

	// register bus group
	logic        sw_brownout_enable_r;
	logic        sw_brownout_enable_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pready_r;
	logic        pready_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic        access;
	logic        setup;
	logic        addr_hit;
	logic [31:0] rd_word;
	wire  [31:0] control_word;
	logic [31:0] status_word;

	////////////////////////////////////////////////////////////////////
	// detector mode decode
	always_comb begin
		circuit_ready = det_en_r & analog_in.det_ready;

		det_en_nxt    = 1'b0;
		wait_ready    = 1'b0;
		sleep_wait    = 1'b0;

		unique case (config_in.brownout_mode_sel)
			RBS_MODE_ON: begin
				det_en_nxt = 1'b1;
				wait_ready = 1'b1;
				sleep_wait = 1'b0;
			end

			RBS_MODE_NOSLP: begin
				det_en_nxt = ~analog_in.sleep;
				wait_ready = 1'b1;
				sleep_wait = ~circuit_ready;
			end

			RBS_MODE_SW: begin
				det_en_nxt = sw_brownout_enable_r;
				wait_ready = 1'b0;
				sleep_wait = 1'b0;
			end

			RBS_MODE_OFF: begin
				det_en_nxt = 1'b0;
				wait_ready = 1'b0;
				sleep_wait = 1'b0;
			end
		endcase

		level_nxt = config_in.brownout_level_sel;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_en_r <= 1'b0;
			level_r  <= 1'b0;
		end else begin
			det_en_r <= det_en_nxt;
			level_r  <= level_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// brown-out filter; the count saturates while the dip lasts
	always_comb begin
		filt_cnt_nxt = filt_cnt_r;
		bor_nxt      = 1'b0;
		filt_done    = (filt_cnt_r >= 32'(FILTER_CYCLES));

		// protection only while detector active and ready
		if (circuit_ready && analog_in.supply_below_bor) begin
			if (filt_done) begin
				bor_nxt = 1'b1;
			end else begin
				filt_cnt_nxt = filt_cnt_r + 32'h1;
			end
		end else begin
			// any return above the trip level restarts the filter
			filt_cnt_nxt = 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bor_r      <= 1'b0;
			filt_cnt_r <= 32'h0;
		end else begin
			bor_r      <= bor_nxt;
			filt_cnt_r <= filt_cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// start-up gate; in the on and no-sleep modes the supply must clear the trip level before release
	always_comb begin
		start_ok = 1'b1;

		if (wait_ready) begin
			// wait for the detector to be ready and the supply above the trip level
			start_ok = circuit_ready & ~analog_in.supply_below_bor;
		end
	end

	////////////////////////////////////////////////////////////////////
	// wake-up gate; only the off-in-sleep mode holds wake_ready low until the detector is ready
	always_comb begin
		wake_ok = 1'b1;

		if (sleep_wait) begin
			wake_ok = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// reset sequence
	always_comb begin
		state_nxt    = state_r;
		powerup_delay_timer_cnt_nxt = powerup_delay_timer_cnt_r;
		core_rst_nxt = 1'b1;
		wake_nxt     = 1'b0;
		powerup_delay_timer_done    = (powerup_delay_timer_cnt_r >= 64'(POWERUP_DELAY_TIMER_CYCLES) - 64'h1);

		unique case (state_r)
			RBS_ST_HOLD: begin
				// restarts on every hold so a late dip gets a full delay
				powerup_delay_timer_cnt_nxt = 64'h0;
				if (!analog_in.power_low && !bor_r) begin
					if (config_in.powerup_delay_disable_n) begin
						state_nxt = RBS_ST_READY;
					end else begin
						state_nxt = RBS_ST_DELAY;
					end
				end
			end

			RBS_ST_DELAY: begin
				if (powerup_delay_timer_done) begin
					state_nxt = RBS_ST_READY;
				end else begin
					powerup_delay_timer_cnt_nxt = powerup_delay_timer_cnt_r + 64'h1;
				end
			end

			RBS_ST_READY: begin
				if (start_ok) begin
					state_nxt = RBS_ST_RUN;
				end
			end

			RBS_ST_RUN: begin
				core_rst_nxt = 1'b0;
				wake_nxt     = wake_ok;
			end
		endcase

		if (analog_in.power_low || bor_r) begin
			state_nxt    = RBS_ST_HOLD;
			core_rst_nxt = 1'b1;
			wake_nxt     = 1'b0;
		end

		if (state_nxt != RBS_ST_RUN) begin
			core_rst_nxt = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			powerup_delay_timer_cnt_r <= 64'h0;
			state_r    <= RBS_ST_HOLD;
			core_rst_r <= 1'b1;
			wake_r     <= 1'b0;
		end else begin
			powerup_delay_timer_cnt_r <= powerup_delay_timer_cnt_nxt;
			state_r    <= state_nxt;
			core_rst_r <= core_rst_nxt;
			wake_r     <= wake_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read-back words; control built bit by bit so spare bits stay zero
	for (genvar i = 0; i < 32; i++) begin : g_ctrl_bit
		if (i == RBS_SWEN_BIT) begin : g_swen
			assign control_word[i] = sw_brownout_enable_r;
		end else if (i == RBS_READY_BIT) begin : g_ready
			assign control_word[i] = circuit_ready;
		end else begin : g_spare
			assign control_word[i] = 1'b0;
		end
	end

	always_comb begin
		status_word                      = 32'h0;
		status_word[RBS_ST_CORE_RST_BIT] = core_rst_r;
		status_word[RBS_ST_DET_EN_BIT]   = det_en_r;
		status_word[RBS_ST_TIMER_BIT]    = (state_r == RBS_ST_DELAY);
		status_word[RBS_ST_BOR_BIT]      = bor_r;
	end

	////////////////////////////////////////////////////////////////////
	// read mux; unmapped offsets read zero
	always_comb begin
		rd_word  = 32'h0;
		addr_hit = 1'b0;

		unique case (paddr)
			RBS_ADDR_CONTROL: begin
				rd_word  = control_word;
				addr_hit = 1'b1;
			end
			RBS_ADDR_STATUS: begin
				rd_word  = status_word;
				addr_hit = 1'b1;
			end
			default: begin
				rd_word  = 32'h0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states: answer prepared at setup
	always_comb begin
		access                 = psel & penable;
		setup                  = psel & ~penable;
		sw_brownout_enable_nxt = sw_brownout_enable_r;
		prdata_nxt             = 32'h0;
		pready_nxt             = 1'b0;
		pslverr_nxt            = 1'b0;

		if (setup) begin
			pready_nxt  = 1'b1;
			// unmapped offsets answer with an error and zero data
			pslverr_nxt = ~addr_hit;
			prdata_nxt  = rd_word;
		end

		// write lands only at the completing edge
		if (access && pready_r && pwrite && !pslverr_r && paddr == RBS_ADDR_CONTROL) begin
			sw_brownout_enable_nxt = pwdata[RBS_SWEN_BIT];
		end

		// hold the answer if an access phase ever runs without it
		if (access && !pready_r) begin
			pready_nxt  = pready_r;
			prdata_nxt  = prdata_r;
			pslverr_nxt = pslverr_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_brownout_enable_r <= RBS_SWEN_RST;
			prdata_r             <= 32'h0;
			pready_r             <= 1'b0;
			pslverr_r            <= 1'b0;
		end else begin
			sw_brownout_enable_r <= sw_brownout_enable_nxt;
			prdata_r             <= prdata_nxt;
			pready_r             <= pready_nxt;
			pslverr_r            <= pslverr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////

	assign prdata             = prdata_r;
	assign pready             = pready_r;
	assign pslverr            = pslverr_r;
	assign detector_enable    = det_en_r;
	assign brownout_level_sel = level_r;
	assign brownout_reset     = bor_r;
	assign core_reset         = core_rst_r;
	assign wake_ready         = wake_r;
endmodule
`default_nettype wire

/* File: sim/rbs_checker.sv */
`default_nettype none
module rbs_checker #(
	parameter longint POWERUP_DELAY_TIMER_CYCLES   = 20,
	parameter int     FILTER_CYCLES = 4
) (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire rbs_pkg::rbs_analog_t analog_in,
	input wire rbs_pkg::rbs_config_t config_in,
	input wire logic                 detector_enable,
	input wire logic                 brownout_level_sel,
	input wire logic                 brownout_reset,
	input wire logic                 core_reset,
	input wire logic                 wake_ready
);
	import rbs_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// low-supply run length; bench dips are short, so no saturation
	logic [7:0] low_cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) low_cnt_r <= 8'h00;
		else low_cnt_r <= analog_in.supply_below_bor ? low_cnt_r + 8'h01 : 8'h00;
	end
	////////////////////////////////////////////////////////////////
	property p_pow; analog_in.power_low |-> ##[1:2] core_reset; endproperty
	a_pow: assert property (p_pow) else $error("core not held at low power");
	property p_on; config_in.brownout_mode_sel == RBS_MODE_ON |=> detector_enable; endproperty
	a_on: assert property (p_on) else $error("detector off in always-on mode");
	property p_off; config_in.brownout_mode_sel == RBS_MODE_OFF |=> !detector_enable; endproperty
	a_off: assert property (p_off) else $error("detector on in off mode");
	property p_slp;
		config_in.brownout_mode_sel == RBS_MODE_NOSLP && analog_in.sleep |=> !detector_enable;
	endproperty
	a_slp: assert property (p_slp) else $error("detector on in sleep");
	property p_wk;
		config_in.brownout_mode_sel == RBS_MODE_NOSLP && !analog_in.det_ready |=> !wake_ready;
	endproperty
	a_wk: assert property (p_wk) else $error("wake before detector ready");
	property p_lvl; 1'b1 |=> brownout_level_sel == $past(config_in.brownout_level_sel); endproperty
	a_lvl: assert property (p_lvl) else $error("trip level not followed");
	property p_flt; $rose(brownout_reset) |-> low_cnt_r > FILTER_CYCLES; endproperty
	a_flt: assert property (p_flt) else $error("brown-out reset on short dip");
	property p_rel;
		$fell(core_reset) |-> !$past(analog_in.power_low) && !$past(brownout_reset);
	endproperty
	a_rel: assert property (p_rel) else $error("core released too early");
	property p_ack; psel && !penable |=> pready; endproperty
	a_ack: assert property (p_ack) else $error("no answer in access cycle");
	property p_rsv;
		pready && paddr == RBS_ADDR_CONTROL |-> prdata[31:8] == 24'h0 && prdata[6:1] == 6'h00;
	endproperty
	a_rsv: assert property (p_rsv) else $error("unimplemented bits not zero");
	c_rel: cover property ($fell(core_reset));
	c_bor: cover property ($rose(brownout_reset));
	c_err: cover property (pready && pslverr);
endmodule
bind rbs_sequencer rbs_checker #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES), .FILTER_CYCLES(FILTER_CYCLES)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.analog_in(analog_in), .config_in(config_in), .detector_enable(detector_enable),
	.brownout_level_sel(brownout_level_sel), .brownout_reset(brownout_reset),
	.core_reset(core_reset), .wake_ready(wake_ready));
`default_nettype wire

/* File: sim/reset_brownout_sequencer_tb.sv */
`default_nettype none
module reset_brownout_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import rbs_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, det_en, lvl, bor, core_reset, wake_ready, er;
	rbs_analog_t an = 4'hA;
	rbs_config_t cf = {RBS_MODE_ON, 2'b00};
	int          fail_count = 0, cmp_count = 0, n;
	always #5 pclk = ~pclk;
	rbs_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(20), .FILTER_CYCLES(4)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_in(an), .config_in(cf),
		.detector_enable(det_en), .brownout_level_sel(lvl), .brownout_reset(bor),
		.core_reset(core_reset), .wake_ready(wake_ready));
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// hold power low, then count edges until the core is let go
	task pup(input rbs_config_t c);
		an.power_low <= 1'b1;
		cf <= c;
		cyc(3);
		an.power_low <= 1'b0;
		n = 0;
		while (core_reset !== 1'b0 && n < 100) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task results;
		$display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge pclk);
		fail_count++;
		results;
	end
	initial begin
		cyc(3);
		presetn <= 1'b1;
		apb(1'b0, RBS_ADDR_CONTROL, 32'h0);
		chk(rd, 32'h81);
		apb(1'b1, RBS_ADDR_CONTROL, 32'hFFFF_FF7E);
		apb(1'b0, RBS_ADDR_CONTROL, 32'h0);
		chk(rd, 32'h01);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("test registers done");
		pup({RBS_MODE_ON, 2'b00});
		chk(n >= 20 && n <= 25, 1);
		pup({RBS_MODE_ON, 2'b11});
		chk({n <= 4, lvl}, 2'b11);
		an.det_ready <= 1'b0;
		pup({RBS_MODE_NOSLP, 2'b01});
		chk(n, 100);
		an.det_ready <= 1'b1;
		cyc(5);
		chk(core_reset, 0);
		an.sleep <= 1'b1;
		cyc(3);
		chk({det_en, wake_ready}, 2'b00);
		an.sleep <= 1'b0;
		cyc(3);
		chk({det_en, wake_ready}, 2'b11);
		$display("test start-up done");
		an.det_ready <= 1'b0;
		pup({RBS_MODE_SW, 2'b01});
		chk({n <= 4, det_en}, 2'b10);
		apb(1'b1, RBS_ADDR_CONTROL, 32'h80);
		cyc(2);
		chk(det_en, 1);
		pup({RBS_MODE_OFF, 2'b01});
		chk({n <= 4, det_en}, 2'b10);
		an.det_ready <= 1'b1;
		pup({RBS_MODE_ON, 2'b01});
		an.sleep <= 1'b1;
		cyc(3);
		chk({det_en, wake_ready}, 2'b11);
		an.sleep <= 1'b0;
		$display("test modes done");
		an.supply_below_bor <= 1'b1;
		cyc(4);
		an.supply_below_bor <= 1'b0;
		cyc(3);
		chk({bor, core_reset}, 2'b00);
		an.supply_below_bor <= 1'b1;
		cyc(10);
		chk({bor, core_reset}, 2'b11);
		an.supply_below_bor <= 1'b0;
		cyc(40);
		chk(core_reset, 0);
		apb(1'b0, RBS_ADDR_STATUS, 32'h0);
		chk(rd, 32'h0000_0002);
		$display("test filter done");
		results;
	end
endmodule
`default_nettype wire
